//--- include/srt_pkg.sv
// Purpose: Shared constants and types for the seconds counter with alarm and trim.
// Assumes: 16-bit registers, each on one aligned 32-bit Avalon word at 4 x index.
// Notes:   Register indices are kept as printed; byte address is index times four.
package srt_pkg;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_INT_STS = 16'h4011;
    localparam logic [15:0] IDX_INT_MASK = 16'h4019;
    localparam logic [15:0] IDX_SEC_KEY = 16'h4007;
    localparam logic [15:0] IDX_TAG = 16'h4020;
    localparam logic [15:0] IDX_TIME_HI = 16'h4021;
    localparam logic [15:0] IDX_TIME_LO = 16'h4022;
    localparam logic [15:0] IDX_ALM_HI = 16'h4023;
    localparam logic [15:0] IDX_ALM_LO = 16'h4024;
    localparam logic [15:0] IDX_CTRL = 16'h4025;
    localparam logic [15:0] IDX_TRIM = 16'h4026;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int BIT_VALID = 15;
    localparam int BIT_BUSY = 14;
    localparam int BIT_ALM_EN = 10;
    localparam int BIT_ALM_EINT = 2;
    localparam int TRIM_W = 10;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_TAG = 16'h0000;
    localparam logic [31:0] RST_TIME = 32'h0000_0000;
    localparam logic [31:0] RST_ALM = 32'h0000_0000;
    localparam logic [9:0] RST_TRIM = 10'h000;
    localparam logic RST_ALM_MASK = 1'h1;

    // ------------------------------------------------------------------
    // Counts and codes
    // ------------------------------------------------------------------
    localparam logic [16:0] OSC_NOMINAL = 17'h08000;
    localparam logic [3:0] MAX_UPDATES = 4'h8;
    localparam logic [11:0] HOUR_SECONDS = 12'hE10;
    // Unlock code value is arbitrary.
    localparam logic [15:0] UNLOCK_KEY = 16'h5A3C;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [1:0] PWR_ON = 2'h0;
    localparam logic [1:0] PWR_SLEEP = 2'h1;
    localparam logic [1:0] PWR_OFF = 2'h2;

    typedef enum logic [1:0] {
        TGT_TIME_HI = 2'h0,
        TGT_TIME_LO = 2'h1,
        TGT_ALM_HI = 2'h2,
        TGT_ALM_LO = 2'h3
    } srt_target_t;

    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b01,
        SYNC_BUSY = 2'b10
    } srt_sync_t;

endpackage : srt_pkg

//--- rtl/srt_lfsr.sv
// Purpose: Free-running pseudo-random source for the tamper tag.
// Assumes: Runs on every system clock, so its value at a write is hard to predict.
// Notes:   Never reaches zero because the seed is non-zero.
module srt_lfsr (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Random word
    output logic [15:0] rand_o
);
    import srt_pkg::*;

    typedef struct packed {
        logic [15:0] lfsr;
    } srt_lfsr_st_t;

    srt_lfsr_st_t r_reg;
    srt_lfsr_st_t r_next;

    always_comb begin
        r_next = r_reg;
        r_next.lfsr = {1'b0, r_reg.lfsr[15:1]} ^ (r_reg.lfsr[0] ? LFSR_TAPS : 16'h0000);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg.lfsr <= LFSR_SEED;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rand_o = r_reg.lfsr;

endmodule // srt_lfsr

//--- rtl/srt_tick.sv
// Purpose: Turns the oscillator pin into a trimmed one-second enable pulse.
// Assumes: Oscillator is far slower than clk_i, so each edge is seen.
// Notes:   Fractional trim is carried over seconds in a 6-bit accumulator.
module srt_tick (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Oscillator and trim
    input wire logic osc_i,
    input wire logic [9:0] trim_i,
    // Enables
    output logic osc_tick_o,
    output logic sec_tick_o
);
    import srt_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [16:0] cnt;
        logic [5:0] frac;
        logic osc_tick;
        logic sec_tick;
    } srt_tick_st_t;

    srt_tick_st_t r_reg;
    srt_tick_st_t r_next;
    logic [6:0] frac_sum;
    logic [4:0] adj;
    logic [16:0] period;

    assign frac_sum = {1'b0, r_reg.frac} + {1'b0, trim_i[5:0]};
    assign adj = {trim_i[9], trim_i[9:6]} + {4'h0, frac_sum[6]};
    assign period = OSC_NOMINAL + {{12{adj[4]}}, adj};

    always_comb begin
        r_next = r_reg;
        r_next.s1 = osc_i;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.osc_tick = r_reg.s2 & ~r_reg.s3;
        r_next.sec_tick = 1'b0;
        if (r_reg.osc_tick) begin
            // A trim lowered mid-second must not strand the count above the period.
            if (r_reg.cnt >= period - 17'h00001) begin
                r_next.cnt = 17'h00000;
                r_next.frac = frac_sum[5:0];
                r_next.sec_tick = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign osc_tick_o = r_reg.osc_tick;
    assign sec_tick_o = r_reg.sec_tick;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_tick_bound;
        r_reg.cnt <= OSC_NOMINAL + 17'h00008;
    endproperty
    a_tick_bound: assert property (p_tick_bound) else $error("second count beyond trimmed range");

    property p_tick_cause;
        sec_tick_o |-> $past(r_reg.osc_tick);
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("second tick without oscillator edge");

endmodule // srt_tick

//--- rtl/srt_core.sv
// Purpose: Seconds counter with match alarm, trim, write limit and tamper tag.
// Assumes: Avalon-MM slave, one wait cycle per access; osc_i is an async pin.
// Notes:   Time and alarm writes are applied at the next rising oscillator edge.
// Notes on behaviour
// - 32-bit seconds count, adds one each second.
// - Count always runs, no enable control.
// - Count high half 4021h, low half 4022h.
// - Valid bit 15 sets on time write.
// - Busy bit 14 while update pending.
// - Tag resets zero, random on time write.
// - At most eight time updates per hour.
// - Alarm high half 4023h, low 4024h.
// - Enabled alarm fires on count match.
// - Match requests wake in sleep, on in off.
// - Trim bits 9:0, signed four-six fixed point.
// - Trim writes need unlocked user key.
// - Time, alarm, tag, trim start at zero.
// - Alarm flag bit 2, write-one clear, masked.
//
// Added by the designer: the Avalon-MM register port.
module srt_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Avalon-MM slave
    input wire logic [17:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Oscillator and power state
    input wire logic osc_i,
    input wire logic [1:0] power_state_i,
    // Alarm outputs
    output logic alarm_irq_o,
    output logic wake_req_o,
    output logic on_req_o
);
    import srt_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [31:0] sec_cnt;
        logic [31:0] alarm;
        logic alm_en;
        logic valid;
        logic [15:0] tag;
        logic [9:0] trim;
        logic unlocked;
        srt_sync_t sync;
        srt_target_t target;
        logic [15:0] pend;
        logic [3:0] upd_cnt;
        logic [11:0] hour_cnt;
        logic match_prev;
        logic alm_flag;
        logic alm_mask;
        logic wake;
        logic on;
    } srt_core_st_t;

    srt_core_st_t r_reg;
    srt_core_st_t r_next;
    logic osc_tick;
    logic sec_tick;
    logic [15:0] rand_word;
    logic [15:0] idx;
    logic fire_wr;
    logic time_wr;
    logic time_acc;
    logic alm_wr;
    logic apply;
    logic match;
    logic alm_rise;
    logic clr_flag;
    logic [15:0] wd;
    logic [15:0] trim_wd;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] be);
        merge16 = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    srt_tick u_tick (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .osc_i(osc_i),
        .trim_i(r_reg.trim),
        .osc_tick_o(osc_tick),
        .sec_tick_o(sec_tick)
    );

    srt_lfsr u_lfsr (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .rand_o(rand_word)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign idx = avs_address_i[17:2];
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~r_reg.ack;
    assign fire_wr = avs_write_i & r_reg.ack;
    assign wd = avs_writedata_i[15:0];
    assign trim_wd = merge16({6'h00, r_reg.trim}, avs_writedata_i, avs_byteenable_i);
    assign time_wr = fire_wr & ((idx == IDX_TIME_HI) | (idx == IDX_TIME_LO));
    assign time_acc = time_wr & (r_reg.upd_cnt < MAX_UPDATES);
    assign alm_wr = fire_wr & ((idx == IDX_ALM_HI) | (idx == IDX_ALM_LO));
    assign apply = (r_reg.sync == SYNC_BUSY) & osc_tick;
    assign match = r_reg.alm_en & (r_reg.sec_cnt == r_reg.alarm);
    assign alm_rise = match & ~r_reg.match_prev;
    assign clr_flag = fire_wr & (idx == IDX_INT_STS) & avs_byteenable_i[0] & wd[BIT_ALM_EINT];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.ack = (avs_read_i | avs_write_i) & ~r_reg.ack;
        if (avs_read_i & ~r_reg.ack) begin
            r_next.rdata = 32'h0000_0000;
            unique case (idx)
                IDX_TAG: r_next.rdata[15:0] = r_reg.tag;
                IDX_TIME_HI: r_next.rdata[15:0] = r_reg.sec_cnt[31:16];
                IDX_TIME_LO: r_next.rdata[15:0] = r_reg.sec_cnt[15:0];
                IDX_ALM_HI: r_next.rdata[15:0] = r_reg.alarm[31:16];
                IDX_ALM_LO: r_next.rdata[15:0] = r_reg.alarm[15:0];
                IDX_CTRL: begin
                    r_next.rdata[BIT_VALID] = r_reg.valid;
                    r_next.rdata[BIT_BUSY] = (r_reg.sync == SYNC_BUSY);
                    r_next.rdata[BIT_ALM_EN] = r_reg.alm_en;
                end
                IDX_TRIM: r_next.rdata[TRIM_W-1:0] = r_reg.trim;
                IDX_INT_STS: r_next.rdata[BIT_ALM_EINT] = r_reg.alm_flag;
                IDX_INT_MASK: r_next.rdata[BIT_ALM_EINT] = r_reg.alm_mask;
                IDX_SEC_KEY: r_next.rdata[0] = r_reg.unlocked;
                default: r_next.rdata = 32'h0000_0000;
            endcase
        end

        r_next.sec_cnt = r_reg.sec_cnt + {31'h0000_0000, sec_tick};
        if (apply) begin
            r_next.sync = SYNC_IDLE;
            unique case (r_reg.target)
                TGT_TIME_HI: r_next.sec_cnt[31:16] = r_reg.pend;
                TGT_TIME_LO: r_next.sec_cnt[15:0] = r_reg.pend;
                TGT_ALM_HI: r_next.alarm[31:16] = r_reg.pend;
                TGT_ALM_LO: r_next.alarm[15:0] = r_reg.pend;
            endcase
        end

        // a write while busy replaces the pending one
        if (time_acc | alm_wr) begin
            r_next.sync = SYNC_BUSY;
            unique case (idx)
                IDX_TIME_HI: begin
                    r_next.target = TGT_TIME_HI;
                    r_next.pend = merge16(r_reg.sec_cnt[31:16], avs_writedata_i, avs_byteenable_i);
                end
                IDX_TIME_LO: begin
                    r_next.target = TGT_TIME_LO;
                    r_next.pend = merge16(r_reg.sec_cnt[15:0], avs_writedata_i, avs_byteenable_i);
                end
                IDX_ALM_HI: begin
                    r_next.target = TGT_ALM_HI;
                    r_next.pend = merge16(r_reg.alarm[31:16], avs_writedata_i, avs_byteenable_i);
                end
                default: begin
                    r_next.target = TGT_ALM_LO;
                    r_next.pend = merge16(r_reg.alarm[15:0], avs_writedata_i, avs_byteenable_i);
                end
            endcase
        end

        if (time_acc) begin
            r_next.valid = 1'b1;
            r_next.tag = rand_word;
        end

        if (sec_tick) begin
            if (r_reg.hour_cnt == HOUR_SECONDS - 12'h001) begin
                r_next.hour_cnt = 12'h000;
            end else begin
                r_next.hour_cnt = r_reg.hour_cnt + 12'h001;
            end
        end
        if (sec_tick & (r_reg.hour_cnt == HOUR_SECONDS - 12'h001)) begin
            r_next.upd_cnt = {3'h0, time_acc};
        end else begin
            r_next.upd_cnt = r_reg.upd_cnt + {3'h0, time_acc};
        end

        if (fire_wr & (idx == IDX_CTRL) & avs_byteenable_i[1]) begin
            r_next.alm_en = wd[BIT_ALM_EN];
        end
        if (fire_wr & (idx == IDX_TRIM) & r_reg.unlocked) begin
            r_next.trim = trim_wd[TRIM_W-1:0];
        end
        if (fire_wr & (idx == IDX_SEC_KEY)) begin
            r_next.unlocked = (merge16(16'h0000, avs_writedata_i, avs_byteenable_i) == UNLOCK_KEY);
        end
        if (fire_wr & (idx == IDX_INT_MASK) & avs_byteenable_i[0]) begin
            r_next.alm_mask = wd[BIT_ALM_EINT];
        end

        r_next.match_prev = match;
        r_next.alm_flag = alm_rise | (r_reg.alm_flag & ~clr_flag);
        r_next.wake = alm_rise & (power_state_i == PWR_SLEEP);
        r_next.on = alm_rise & (power_state_i == PWR_OFF);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg <= '0;
            r_reg.sec_cnt <= RST_TIME;
            r_reg.alarm <= RST_ALM;
            r_reg.tag <= RST_TAG;
            r_reg.trim <= RST_TRIM;
            r_reg.alm_mask <= RST_ALM_MASK;
            r_reg.sync <= SYNC_IDLE;
            r_reg.target <= TGT_TIME_HI;
        end else begin
            r_reg <= r_next;
        end
    end

    assign avs_readdata_o = r_reg.rdata;
    assign alarm_irq_o = r_reg.alm_flag & ~r_reg.alm_mask;
    assign wake_req_o = r_reg.wake;
    assign on_req_o = r_reg.on;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_sec_step;
        sec_tick && !apply |=> r_reg.sec_cnt == $past(r_reg.sec_cnt) + 32'h0000_0001;
    endproperty
    a_sec_step: assert property (p_sec_step) else $error("count did not step by one");

    property p_run;
        !sec_tick && !apply |=> $stable(r_reg.sec_cnt);
    endproperty
    a_run: assert property (p_run) else $error("count moved without a tick");

    property p_read_hi;
        avs_read_i && !r_reg.ack && idx == IDX_TIME_HI
            |=> avs_readdata_o == {16'h0000, $past(r_reg.sec_cnt[31:16])} && !avs_waitrequest_o;
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("high count read wrong");

    property p_valid;
        time_acc |=> r_reg.valid;
    endproperty
    a_valid: assert property (p_valid) else $error("valid bit not set");

    sequence s_upd_start;
        time_acc || alm_wr;
    endsequence
    sequence s_upd_wait;
        r_reg.sync == SYNC_BUSY && !osc_tick;
    endsequence
    property p_busy;
        s_upd_start ##1 s_upd_wait |=> r_reg.sync == SYNC_BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped before apply");

    property p_tag;
        time_acc |=> r_reg.tag == $past(rand_word);
    endproperty
    a_tag: assert property (p_tag) else $error("tag not reloaded");

    property p_limit;
        time_wr && !time_acc |=> $stable(r_reg.tag) && r_reg.upd_cnt <= MAX_UPDATES;
    endproperty
    a_limit: assert property (p_limit) else $error("update beyond limit accepted");

    property p_alm_apply;
        apply && r_reg.target == TGT_ALM_LO && !(time_acc || alm_wr)
            |=> r_reg.alarm[15:0] == $past(r_reg.pend) && r_reg.sync == SYNC_IDLE;
    endproperty
    a_alm_apply: assert property (p_alm_apply) else $error("alarm low half not applied");

    property p_alarm;
        r_reg.alm_en && r_reg.sec_cnt == r_reg.alarm && !r_reg.match_prev |=> r_reg.alm_flag;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm match not flagged");

    property p_wake;
        alm_rise && power_state_i == PWR_SLEEP |=> wake_req_o ##1 !wake_req_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake request missing");

    property p_trim_lock;
        fire_wr && idx == IDX_TRIM && !r_reg.unlocked |=> $stable(r_reg.trim);
    endproperty
    a_trim_lock: assert property (p_trim_lock) else $error("locked trim changed");

    property p_flag_clear;
        clr_flag && !alm_rise |=> !r_reg.alm_flag && !alarm_irq_o;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("alarm flag not cleared");

endmodule // srt_core

//--- verification/seconds_rtc_with_alarm_trim_tb_top.sv
// Purpose: Self-checking bench for the seconds counter, alarm, trim and write limit.
// Assumes: One wait cycle per access; osc_i driven here, 16 clk_i cycles per period, 2 in the fast phase.
// Notes:   The oscillator runs fast only at the end, so the count holds still for alarm matching.
module seconds_rtc_with_alarm_trim_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import srt_pkg::*;

    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [17:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'h3;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic osc_i = 1'b0;
    logic osc_run = 1'b0;
    logic osc_fast = 1'b0;
    logic [1:0] power_state_i = PWR_ON;
    logic alarm_irq_o;
    logic wake_req_o;
    logic on_req_o;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_wake = 0;
    int n_on = 0;
    logic [63:0] exp_q[$];
    logic [63:0] mon_e;
    logic [15:0] seed = 16'h005C;
    logic [31:0] rd;
    logic [15:0] hi, lo, v, tag;

    srt_core uut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .osc_i(osc_i),
        .power_state_i(power_state_i), .alarm_irq_o(alarm_irq_o), .wake_req_o(wake_req_o), .on_req_o(on_req_o)
    );

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // Holding the oscillator lets the bench keep an update pending on purpose.
    // The fast rate exists only so that one whole second fits in the run.
    initial begin
        forever begin
            repeat (osc_fast ? 1 : 8) @(posedge clk_i);
            if (osc_run) osc_i <= ~osc_i;
        end
    end

    function automatic logic [15:0] xs(input logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        x ^= x << 8;
        return x;
    endfunction

    task automatic next_rand(output logic [15:0] r);
        seed = xs(seed);
        r = seed;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // One Avalon access; a read notes its expected value for the monitor first.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd, input logic [15:0] msk,
                       input logic [15:0] ex);
        @(posedge clk_i);
        if (!wr) exp_q.push_back(msk != 0 ? {16'hFFFF, msk, 16'h0000, ex} : 64'h0);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= {16'h0000, wd};
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic rdx(input logic [15:0] idx, input logic [15:0] ex);
        bus(1'b0, idx, 16'h0000, 16'hFFFF, ex);
    endtask

    task automatic wrx(input logic [15:0] idx, input logic [15:0] d);
        bus(1'b1, idx, d, 16'h0000, 16'h0000);
    endtask

    task automatic wait_sync;
        int k;
        k = 0;
        do begin
            bus(1'b0, IDX_CTRL, 16'h0000, 16'h0000, 16'h0000);
            k++;
        end while (rd[BIT_BUSY] !== 1'b0 && k < 40);
        check(32'(rd[BIT_BUSY]), 32'h0);
    endtask

    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            if (mon_e[63:32] != 0) check(avs_readdata_o & mon_e[63:32], mon_e[31:0]);
        end
        if (wake_req_o === 1'b1) n_wake++;
        if (on_req_o === 1'b1) n_on++;
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 7; i++) rdx(IDX_TAG + 16'(i), 16'h0000);
        rdx(IDX_INT_STS, 16'h0000);
        rdx(IDX_INT_MASK, 16'h0004);
        wrx(16'h4030, 16'hFFFF);
        rdx(16'h4030, 16'h0000);
        next_rand(hi);
        wrx(IDX_TIME_HI, hi);
        rdx(IDX_CTRL, 16'hC000);
        osc_run <= 1'b1;
        wait_sync;
        rdx(IDX_TIME_HI, hi);
        rdx(IDX_CTRL, 16'h8000);
        bus(1'b0, IDX_TAG, 16'h0000, 16'h0000, 16'h0000);
        tag = rd[15:0];
        check(32'(tag != 16'h0000), 32'h1);
        lo = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            next_rand(v);
            wrx(IDX_TIME_LO, v);
            wait_sync;
            if (i < 7) lo = v;
            rdx(IDX_TIME_LO, lo);
            bus(1'b0, IDX_TAG, 16'h0000, 16'h0000, 16'h0000);
            check(32'(rd[15:0] != tag), 32'(i < 7));
            tag = rd[15:0];
        end
        rdx(IDX_TIME_HI, hi);
        wrx(IDX_TRIM, 16'h02F2);
        rdx(IDX_TRIM, 16'h0000);
        wrx(IDX_SEC_KEY, UNLOCK_KEY);
        rdx(IDX_SEC_KEY, 16'h0001);
        wrx(IDX_TRIM, 16'hFFFF);
        rdx(IDX_TRIM, 16'h03FF);
        wrx(IDX_TRIM, 16'h02F2);
        rdx(IDX_TRIM, 16'h02F2);
        wrx(IDX_ALM_HI, hi);
        wait_sync;
        wrx(IDX_ALM_LO, lo);
        wait_sync;
        rdx(IDX_ALM_HI, hi);
        rdx(IDX_ALM_LO, lo);
        wrx(IDX_INT_MASK, 16'h0000);
        power_state_i <= PWR_SLEEP;
        check(32'(alarm_irq_o), 32'h0);
        wrx(IDX_CTRL, 16'h0400);
        repeat (4) @(posedge clk_i);
        check(32'(alarm_irq_o), 32'h1);
        check(32'(n_wake), 32'h1);
        check(32'(n_on), 32'h0);
        rdx(IDX_INT_STS, 16'h0004);
        rdx(IDX_CTRL, 16'h8400);
        wrx(IDX_INT_STS, 16'h0004);
        rdx(IDX_INT_STS, 16'h0000);
        check(32'(alarm_irq_o), 32'h0);
        wrx(IDX_CTRL, 16'h0000);
        power_state_i <= PWR_OFF;
        wrx(IDX_CTRL, 16'h0400);
        repeat (4) @(posedge clk_i);
        check(32'(n_on), 32'h1);
        check(32'(n_wake), 32'h1);
        rdx(IDX_INT_STS, 16'h0004);
        wrx(IDX_INT_MASK, 16'h0004);
        repeat (2) @(posedge clk_i);
        check(32'(alarm_irq_o), 32'h0);
        // one second with trim at -8 Hz
        wrx(IDX_TRIM, 16'h0200);
        rdx(IDX_TRIM, 16'h0200);
        osc_fast <= 1'b1;
        do begin
            bus(1'b0, IDX_TIME_LO, 16'h0000, 16'h0000, 16'h0000);
        end while (rd[15:0] === lo);
        check(32'(rd[15:0]), 32'(lo + 16'h0001));
        rdx(IDX_TIME_HI, hi + 16'(lo == 16'hFFFF));
        report_and_stop;
    end
endmodule // seconds_rtc_with_alarm_trim_tb_top
